// File: src/dpp_top.sv
`timescale 1ns/100ps
module dpp_top
   import dpp_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // register port
   input wire dpp_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   // configuration
   input wire logic capture_unit2_pin_select,
   input wire dpp_dbg_t in_circuit_debug,
   // peripherals
   input wire dpp_ovr_t port_c_ovr,
   input wire dpp_cap2_t cap2_ctl,
   output logic cap2_in,
   output logic dbg_clk_in,
   output logic dbg_data_in,
   // first port pins
   input wire logic [7:0] b_pin_i,
   output logic [7:0] b_pin_o,
   output logic [7:0] b_pin_oe,
   output logic [7:0] b_pullup_en,
   output logic [7:0] b_analog_en,
   // second port pins
   input wire logic [7:0] c_pin_i,
   output logic [7:0] c_pin_o,
   output logic [7:0] c_pin_oe
);
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   // channel ch is analog while ch < 15 - field; field 0 = all analog
   function automatic logic [7:0] analog_mask(input logic [3:0] cfg);
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < AN_PINS; i++) begin
         m[i] = ({1'b0, AN_CH[i]} < (5'(CH_LIMIT) - {1'b0, cfg}));
      end
      return m;
   endfunction : analog_mask

   function automatic logic hit(input dpp_bus_req_t r, input dpp_addr_t a);
      return r.wr && (r.addr == a);
   endfunction : hit

   // ---------------------------------------------
   // register state
   // ---------------------------------------------
   logic [7:0] b_latch_q;
   logic [7:0] b_dir_q;
   logic [7:0] c_latch_q;
   logic [7:0] c_dir_q;
   logic [7:0] int_main_q;
   logic [7:0] int_edge_q;
   logic [7:0] int_ext_q;
   logic [7:0] analog_cfg_q;
   logic [7:0] b_sync1_q;
   logic [7:0] b_sync_q;
   logic [7:0] c_sync1_q;
   logic [7:0] c_sync_q;
   logic [7:0] rdata_q;
   logic cap2_in_q;
   logic dbg_clk_q;
   logic dbg_data_q;

   // latch written by either the latch or the pin-level address
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         b_latch_q <= RST_LATCH;
         c_latch_q <= RST_LATCH;
      end else begin
         if (hit(bus_req, OFS_B_LATCH) || hit(bus_req, OFS_B_PINS)) begin
            b_latch_q <= bus_req.wdata;
         end
         if (hit(bus_req, OFS_C_LATCH) || hit(bus_req, OFS_C_PINS)) begin
            c_latch_q <= bus_req.wdata;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         b_dir_q <= RST_DIR;
         c_dir_q <= RST_DIR;
      end else begin
         if (hit(bus_req, OFS_B_DIR)) begin
            b_dir_q <= bus_req.wdata;
         end
         if (hit(bus_req, OFS_C_DIR)) begin
            c_dir_q <= bus_req.wdata;
         end
      end
   end

   // no interrupt logic lives here; int_edge_q bit 7 and analog_cfg_q also drive pin control
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         int_main_q <= RST_INT_MAIN;
         int_edge_q <= RST_INT_EDGE;
         int_ext_q <= RST_INT_EXT;
         analog_cfg_q <= RST_ANALOG_CFG;
      end else begin
         if (hit(bus_req, OFS_INT_MAIN)) begin
            int_main_q <= bus_req.wdata;
         end
         if (hit(bus_req, OFS_INT_EDGE)) begin
            int_edge_q <= bus_req.wdata & MSK_INT_EDGE;
         end
         if (hit(bus_req, OFS_INT_EXT)) begin
            int_ext_q <= bus_req.wdata & MSK_INT_EXT;
         end
         if (hit(bus_req, OFS_ANALOG_CFG)) begin
            analog_cfg_q <= bus_req.wdata & MSK_ANALOG_CFG;
         end
      end
   end

   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         b_sync1_q <= 8'h00;
         b_sync_q <= 8'h00;
         c_sync1_q <= 8'h00;
         c_sync_q <= 8'h00;
      end else begin
         b_sync1_q <= b_pin_i;
         b_sync_q <= b_sync1_q;
         c_sync1_q <= c_pin_i;
         c_sync_q <= c_sync1_q;
      end
   end

   // ---------------------------------------------
   // first port pin control
   // ---------------------------------------------
   logic [7:0] b_analog;
   logic [7:0] b_digin;
   logic [7:0] b_dbg_mask;
   logic cap2_on_b;
   logic cap2_on_c;

   always_comb begin
      b_analog = analog_mask(analog_cfg_q[3:0]);
      b_dbg_mask = 8'h00;
      if (in_circuit_debug.en) begin
         b_dbg_mask[DBG_CLK_BIT] = 1'b1;
         b_dbg_mask[DBG_DATA_BIT] = 1'b1;
      end
      // input buffer off on analog pins
      b_digin = b_sync_q & ~b_analog;
      cap2_on_b = !capture_unit2_pin_select && cap2_ctl.out_en;
      cap2_on_c = capture_unit2_pin_select && cap2_ctl.out_en;
   end

   always_comb begin
      b_pin_oe = ~b_dir_q;
      b_pin_o = b_latch_q;
      if (cap2_on_b) begin
         b_pin_oe[CAP2_B_BIT] = 1'b1;
         b_pin_o[CAP2_B_BIT] = cap2_ctl.out_val;
      end
      // debug owns both pins whatever the direction bits say
      if (in_circuit_debug.en) begin
         b_pin_oe[DBG_CLK_BIT] = 1'b0;
         b_pin_o[DBG_CLK_BIT] = 1'b0;
         b_pin_oe[DBG_DATA_BIT] = in_circuit_debug.data_oe;
         b_pin_o[DBG_DATA_BIT] = in_circuit_debug.data_o;
      end
   end

   always_comb begin
      b_analog_en = b_analog & ~b_dbg_mask;
      b_pullup_en = {8{~int_edge_q[PULLUP_DIS_BIT]}} & b_dir_q;
      b_pullup_en = b_pullup_en & ~b_analog & ~b_dbg_mask;
      if (cap2_on_b) begin
         b_pullup_en[CAP2_B_BIT] = 1'b0;
      end
   end

   // ---------------------------------------------
   // second port pin control
   // ---------------------------------------------
   // force_in wins over force_out if a peripheral drives both
   always_comb begin
      c_pin_oe = (~c_dir_q | port_c_ovr.force_out) & ~port_c_ovr.force_in;
      c_pin_o = (c_latch_q & ~port_c_ovr.force_out)
              | (port_c_ovr.data & port_c_ovr.force_out);
      if (cap2_on_c) begin
         c_pin_oe[CAP2_C_BIT] = 1'b1;
         c_pin_o[CAP2_C_BIT] = cap2_ctl.out_val;
      end
   end

   // ---------------------------------------------
   // peripheral inputs, registered
   // ---------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cap2_in_q <= 1'b0;
         dbg_clk_q <= 1'b0;
         dbg_data_q <= 1'b0;
      end else begin
         cap2_in_q <= capture_unit2_pin_select ? c_sync_q[CAP2_C_BIT]
                                               : b_sync_q[CAP2_B_BIT];
         dbg_clk_q <= in_circuit_debug.en & b_sync_q[DBG_CLK_BIT];
         dbg_data_q <= in_circuit_debug.en & b_sync_q[DBG_DATA_BIT];
      end
   end

   assign cap2_in = cap2_in_q;
   assign dbg_clk_in = dbg_clk_q;
   assign dbg_data_in = dbg_data_q;

   // ---------------------------------------------
   // read port
   // ---------------------------------------------
   // data stand one cycle only, zero otherwise
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 8'h00;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            OFS_B_PINS: rdata_q <= b_digin;
            OFS_B_LATCH: rdata_q <= b_latch_q;
            OFS_B_DIR: rdata_q <= b_dir_q;
            OFS_INT_MAIN: rdata_q <= int_main_q;
            OFS_INT_EDGE: rdata_q <= int_edge_q;
            OFS_INT_EXT: rdata_q <= int_ext_q;
            OFS_ANALOG_CFG: rdata_q <= analog_cfg_q;
            OFS_C_PINS: rdata_q <= c_sync_q;
            OFS_C_LATCH: rdata_q <= c_latch_q;
            OFS_C_DIR: rdata_q <= c_dir_q;
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign bus_rdata = rdata_q;
endmodule : dpp_top

// File: src/dpp_pkg.sv
// What this block does
// - second port: eight pins, own direction bits
// - direction bit 1 floats the pin
// - direction bit 0 drives latch bit
// - latch addressable; read-modify-write uses latch
// - unit-2 pin select picks C1 or B3
// - enabled peripheral overrides stored direction
// - power-on reset makes all pins inputs
// - direction read returns stored bits
// - analog-capable first-port pins default analog
// - debug mode disables other clock/data functions
// - don't-care functions ignore the direction bit
// - unimplemented control bits read zero
// - pull-up bit clear enables digital-input pull-ups
// - analog pin: no input buffer, no pull-up; cap2_in still samples B3 unmasked when B3 is analog
// - unit-2 compare output beats latch data
package dpp_pkg;
   typedef logic [3:0] dpp_addr_t;
   typedef logic [7:0] dpp_byte_t;
   // ---------------------------------------------
   // register offsets
   // ---------------------------------------------
   localparam dpp_addr_t OFS_B_PINS = 4'h0;
   localparam dpp_addr_t OFS_B_LATCH = 4'h1;
   localparam dpp_addr_t OFS_B_DIR = 4'h2;
   localparam dpp_addr_t OFS_INT_MAIN = 4'h3;
   localparam dpp_addr_t OFS_INT_EDGE = 4'h4;
   localparam dpp_addr_t OFS_INT_EXT = 4'h5;
   localparam dpp_addr_t OFS_ANALOG_CFG = 4'h6;
   localparam dpp_addr_t OFS_C_PINS = 4'h8;
   localparam dpp_addr_t OFS_C_LATCH = 4'h9;
   localparam dpp_addr_t OFS_C_DIR = 4'hA;
   // ---------------------------------------------
   // reset values and implemented-bit masks
   // ---------------------------------------------
   localparam dpp_byte_t RST_DIR = 8'hFF;
   localparam dpp_byte_t RST_LATCH = 8'h00;
   localparam dpp_byte_t RST_INT_MAIN = 8'h00;
   localparam dpp_byte_t RST_INT_EDGE = 8'h80;
   localparam dpp_byte_t RST_INT_EXT = 8'h00;
   localparam dpp_byte_t RST_ANALOG_CFG = 8'h00;
   localparam dpp_byte_t MSK_INT_EDGE = 8'hF5;
   localparam dpp_byte_t MSK_INT_EXT = 8'hDB;
   localparam dpp_byte_t MSK_ANALOG_CFG = 8'h3F;
   // ---------------------------------------------
   // field positions
   // ---------------------------------------------
   localparam int PULLUP_DIS_BIT = 7;
   localparam int CAP2_B_BIT = 3;
   localparam int CAP2_C_BIT = 1;
   localparam int DBG_CLK_BIT = 6;
   localparam int DBG_DATA_BIT = 7;
   localparam int AN_PINS = 5;
   localparam int CH_LIMIT = 15;
   // analog channel of first-port bits 0..4
   localparam logic [3:0] AN_CH [AN_PINS] = '{4'hC, 4'hA, 4'h8, 4'h9, 4'hB};
   // ---------------------------------------------
   // carriers
   // ---------------------------------------------
   typedef struct packed {
      dpp_addr_t addr;
      dpp_byte_t wdata;
      logic wr;
      logic rd;
   } dpp_bus_req_t;
   typedef struct packed {
      dpp_byte_t force_out;
      dpp_byte_t force_in;
      dpp_byte_t data;
   } dpp_ovr_t;
   typedef struct packed {
      logic out_en;
      logic out_val;
   } dpp_cap2_t;
   typedef struct packed {
      logic en;
      logic data_oe;
      logic data_o;
   } dpp_dbg_t;
endpackage : dpp_pkg

// File: dv/dpp_monitor.sv
`timescale 1ns/100ps
module dpp_monitor
   import dpp_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // register port
   input wire dpp_bus_req_t bus_req,
   input wire logic [7:0] bus_rdata,
   // configuration and peripherals
   input wire logic capture_unit2_pin_select,
   input wire dpp_dbg_t in_circuit_debug,
   input wire dpp_ovr_t port_c_ovr,
   input wire dpp_cap2_t cap2_ctl,
   // pins
   input wire logic [7:0] b_pin_o,
   input wire logic [7:0] b_pin_oe,
   input wire logic [7:0] b_pullup_en,
   input wire logic [7:0] b_analog_en,
   input wire logic [7:0] c_pin_o,
   input wire logic [7:0] c_pin_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   chk_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
      else $error("read data not idle");
   chk_reset_inputs: assert property ($rose(arst_n) && !cap2_ctl.out_en
      |-> (c_pin_oe & ~port_c_ovr.force_out) == 8'h00) else $error("pin driven after reset");
   chk_force_in: assert property ((c_pin_oe & port_c_ovr.force_in & 8'hFD) == 8'h00)
      else $error("forced input driven");
   chk_force_out: assert property (
      (port_c_ovr.force_out & ~port_c_ovr.force_in & ~c_pin_oe) == 8'h00)
      else $error("forced output floats");
   chk_latch_drive: assert property (bus_req.wr && bus_req.addr == OFS_C_LATCH ##1
      port_c_ovr.force_out == 8'h00 && !cap2_ctl.out_en
      |-> ((c_pin_o ^ $past(bus_req.wdata)) & c_pin_oe) == 8'h00) else $error("latch not driven");
   chk_cap2_on_c: assert property (cap2_ctl.out_en && capture_unit2_pin_select
      && !port_c_ovr.force_in[1] |-> c_pin_oe[1] && c_pin_o[1] == cap2_ctl.out_val)
      else $error("unit 2 output lost on port c");
   chk_cap2_on_b: assert property (cap2_ctl.out_en && !capture_unit2_pin_select
      |-> b_pin_oe[3] && b_pin_o[3] == cap2_ctl.out_val) else $error("unit 2 output lost on b3");
   chk_debug_pins: assert property (in_circuit_debug.en |-> !b_pin_oe[6]
      && b_pin_oe[7] == in_circuit_debug.data_oe) else $error("debug pins not owned");
   chk_analog_pullup: assert property ((b_analog_en & b_pullup_en) == 8'h00)
      else $error("pull-up on analog pin");
   cov_cap2_c: cover property (cap2_ctl.out_en && capture_unit2_pin_select);
   cov_debug: cover property (in_circuit_debug.en && in_circuit_debug.data_oe);
   cov_force: cover property (port_c_ovr.force_out != 8'h00);
endmodule : dpp_monitor
bind dpp_top dpp_monitor u_monitor (.*);

// File: dv/dpp_far_side.sv
`timescale 1ns/100ps
module dpp_far_side
(
   // design side
   input wire logic core_clk,
   input wire logic [7:0] b_pin_o,
   input wire logic [7:0] b_pin_oe,
   input wire logic [7:0] b_pullup_en,
   input wire logic [7:0] c_pin_o,
   input wire logic [7:0] c_pin_oe,
   // board side
   input wire logic [7:0] b_ext,
   input wire logic [7:0] b_ext_en,
   input wire logic [7:0] c_ext,
   output logic [7:0] b_pin_i,
   output logic [7:0] c_pin_i
);
   logic [7:0] float_q = 8'h55;
   // undriven first-port lines with no board drive or pull-up wander so a stale level never passes for a real one
   always_ff @(posedge core_clk) float_q <= ~float_q;
   assign b_pin_i = (b_pin_oe & b_pin_o) | (~b_pin_oe & b_ext_en & b_ext)
      | (~b_pin_oe & ~b_ext_en & (b_pullup_en | float_q));
   assign c_pin_i = (c_pin_oe & c_pin_o) | (~c_pin_oe & c_ext);
endmodule : dpp_far_side

// File: dv/test_dual_port_pin_logic.sv
`timescale 1ns/100ps
module test_dual_port_pin_logic;
   import dpp_pkg::*;
   logic core_clk, arst_n, capture_unit2_pin_select, cap2_in, dbg_clk_in, dbg_data_in;
   logic [7:0] bus_rdata, b_pin_i, b_pin_o, b_pin_oe, b_pullup_en, b_analog_en, b_ext, b_ext_en;
   logic [7:0] c_pin_i, c_pin_o, c_pin_oe, c_ext, dir, lat, fo, fi;
   dpp_bus_req_t bus_req;
   dpp_dbg_t in_circuit_debug;
   dpp_ovr_t port_c_ovr;
   dpp_cap2_t cap2_ctl;
   int miscompares, n_compared, seed;
   dpp_addr_t ma[3] = '{OFS_INT_EDGE, OFS_INT_EXT, OFS_ANALOG_CFG};
   dpp_byte_t mv[3] = '{MSK_INT_EDGE, MSK_INT_EXT, MSK_ANALOG_CFG};
   dpp_top uut (.core_clk, .arst_n, .bus_req, .bus_rdata, .capture_unit2_pin_select,
      .in_circuit_debug, .port_c_ovr, .cap2_ctl, .cap2_in, .dbg_clk_in, .dbg_data_in,
      .b_pin_i, .b_pin_o, .b_pin_oe, .b_pullup_en, .b_analog_en, .c_pin_i, .c_pin_o, .c_pin_oe);
   dpp_far_side u_far (.core_clk, .b_pin_o, .b_pin_oe, .b_pullup_en, .c_pin_o, .c_pin_oe,
      .b_ext, .b_ext_en, .c_ext, .b_pin_i, .c_pin_i);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   function automatic logic [7:0] pin_level(input logic [7:0] oe, o, ext);
      return (oe & o) | (~oe & ext);
   endfunction : pin_level
   task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task automatic wr(input dpp_addr_t a, input dpp_byte_t d);
      @(posedge core_clk);
      bus_req.wr <= 1'b1;
      bus_req.addr <= a;
      bus_req.wdata <= d;
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rdc(input string nm, input dpp_addr_t a, input dpp_byte_t e);
      @(posedge core_clk);
      bus_req.rd <= 1'b1;
      bus_req.addr <= a;
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      #1 cmp(nm, e, bus_rdata);
   endtask : rdc
   task automatic settle;
      repeat (4) @(posedge core_clk);
      #1;
   endtask : settle
   task automatic wrap_up;
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      wrap_up();
   end
   initial begin
      seed = 32'h01CC;
      {arst_n, bus_req, capture_unit2_pin_select, in_circuit_debug} = '0;
      {port_c_ovr, cap2_ctl, b_ext, c_ext} = '0;
      b_ext_en = 8'hC0;
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      #1 cmp("c_oe", 8'h00, c_pin_oe);
      cmp("analog", 8'h1F, b_analog_en);
      rdc("c_dir", OFS_C_DIR, RST_DIR);
      rdc("hole", 4'hF, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(ma[i], 8'hFF);
         rdc("mask", ma[i], mv[i]);
      end
      cmp("analog", 8'h00, b_analog_en);
      wr(OFS_INT_EDGE, 8'h00);
      cmp("pullup", 8'hFF, b_pullup_en);
      wr(OFS_ANALOG_CFG, 8'h00);
      cmp("pullup", 8'hE0, b_pullup_en);
      wr(OFS_B_DIR, 8'h0F);
      wr(OFS_B_LATCH, 8'h5A);
      cmp("b_oe", 8'hF0, b_pin_oe);
      cmp("b_o", 8'h5A, b_pin_o);
      settle();
      rdc("b_pins", OFS_B_PINS, 8'h40);
      wr(OFS_B_DIR, 8'hFF);
      $display("test registers done");
      for (int i = 0; i < 10; i++) begin
         dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
         lat = 8'($random(seed));
         wr(OFS_C_DIR, dir);
         wr(i[0] ? OFS_C_PINS : OFS_C_LATCH, lat);
         @(posedge core_clk);
         c_ext <= 8'($random(seed));
         settle();
         cmp("c_oe", ~dir, c_pin_oe);
         cmp("c_o", lat & ~dir, c_pin_o & ~dir);
         rdc("c_dir", OFS_C_DIR, dir);
         rdc("c_lat", OFS_C_LATCH, lat);
         rdc("c_pins", OFS_C_PINS, pin_level(~dir, lat, c_ext));
      end
      $display("test port c done");
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      #1 cmp("c_oe", 8'h00, c_pin_oe);
      rdc("c_dir", OFS_C_DIR, RST_DIR);
      wr(OFS_C_DIR, 8'hFF);
      fo = 8'($random(seed));
      fi = 8'($random(seed));
      @(posedge core_clk);
      port_c_ovr <= '{force_out: fo, force_in: fi, data: 8'hA5};
      settle();
      cmp("ovr_oe", fo & ~fi, c_pin_oe);
      cmp("ovr_o", 8'hA5 & fo & ~fi, c_pin_o & c_pin_oe);
      rdc("c_dir", OFS_C_DIR, 8'hFF);
      @(posedge core_clk);
      port_c_ovr <= '0;
      // board holds b3 low so the capture input has a known level
      b_ext_en <= 8'hC8;
      for (int v = 0; v < 2; v++) begin
         @(posedge core_clk);
         capture_unit2_pin_select <= v[0];
         cap2_ctl <= '{out_en: 1'b1, out_val: ~v[0]};
         c_ext <= {6'h00, v[0], 1'b0};
         settle();
         cmp("cap2", {7'h00, ~v[0]}, {7'h00, v[0] ? c_pin_o[1] : b_pin_o[3]});
         @(posedge core_clk);
         cap2_ctl <= '0;
         settle();
         cmp("cap2_in", {7'h00, v[0]}, {7'h00, cap2_in});
      end
      $display("test overrides done");
      @(posedge core_clk);
      in_circuit_debug <= '{en: 1'b1, data_oe: 1'b1, data_o: 1'b1};
      b_ext <= 8'h40;
      settle();
      cmp("dbg", 8'h07, {5'h00, dbg_data_in, dbg_clk_in, b_pin_o[7]});
      @(posedge core_clk);
      in_circuit_debug <= '0;
      settle();
      cmp("dbg_off", 8'h00, {7'h00, dbg_clk_in});
      $display("test debug done");
      wrap_up();
   end
endmodule : test_dual_port_pin_logic
